// file: inc/bcdco_pkg.sv
// Package of register offsets, field layouts and timing constants for the clock block
package bcdco_pkg;
	// Register offsets (byte registers on the plain port)
	localparam logic [7:0] OFS_FREQ_CTRL  = 8'h56;
	localparam logic [7:0] OFS_RANGE_CTRL = 8'h57;
	localparam logic [7:0] OFS_CLK_CTRL   = 8'h58;
	localparam logic [7:0] OFS_AUX_CTRL   = 8'h53;
	localparam logic [7:0] OFS_STATUS     = 8'h5a;
	// Frequency control fields: tap in [7:5], modulation count in [4:0]
	localparam int TAP_LSB = 5;
	localparam int TAP_W   = 3;
	localparam int MOD_LSB = 0;
	localparam int MOD_W   = 5;
	// Range control: range select in [3:0]
	localparam int RSEL_LSB = 0;
	localparam int RSEL_W   = 4;
	// Clock control: main source [1:0], peripheral source [3:2]
	localparam int MSRC_LSB = 0;
	localparam int PSRC_LSB = 2;
	localparam int SRC_W    = 2;
	// Aux control: bit 0 selects internal low-frequency oscillator
	localparam int AUX_SEL_BIT = 0;
	// Reset values
	localparam logic [7:0] RST_FREQ_CTRL  = 8'h60;
	localparam logic [7:0] RST_RANGE_CTRL = 8'h07;
	localparam logic [7:0] RST_CLK_CTRL   = 8'h00;
	localparam logic [7:0] RST_AUX_CTRL   = 8'h00;
	// Modulation frame length in oscillator cycles
	localparam int FRAME_LEN = 32;
	// Oscillator start time and clock rate
	localparam int SETTLE_NS  = 1000;
	localparam int CLK_MHZ    = 50;
	localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ) / 1000;
	// Clock sources for main and peripheral clocks
	typedef enum logic [1:0] {
		BCDCO_SRC_OSC = 2'h0,
		BCDCO_SRC_AUX = 2'h1,
		BCDCO_SRC_OFF = 2'h2
	} bcdco_src_t;
endpackage : bcdco_pkg

// file: hdl/bcdco_modulator.sv
// Fractional tap modulator spreading higher-tap cycles across a 32-cycle frame
module bcdco_modulator
#(
	parameter int MOD_W = 5
)
(
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             osc_tick,
	input  wire logic [MOD_W-1:0] modulation_count,
	output logic                  use_higher_q,
	output logic                  frame_start_q
);
	localparam logic [MOD_W:0] FULL = (MOD_W+1)'(1 << MOD_W);

	initial
	begin
		if (MOD_W < 1 || MOD_W > 8)
			$error("bcdco_modulator: MOD_W out of range");
	end

	logic [MOD_W-1:0] phase_q;
	logic [MOD_W:0]   acc_q;
	logic [MOD_W:0]   sum;

	// Accumulator spreads higher cycles evenly, keeping period jitter small
	assign sum = acc_q + {1'b0, modulation_count};

	// Phase counter and error accumulator advance once per oscillator cycle
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			phase_q       <= '0;
			acc_q         <= '0;
			use_higher_q  <= 1'b0;
			frame_start_q <= 1'b0;
		end
		else if (osc_tick)
		begin
			phase_q       <= phase_q + 1'b1;
			frame_start_q <= (phase_q == '0);
			if (phase_q == '0)
			begin
				// Frame restart keeps exactly the programmed count per frame
				// First cycle stays on the base tap; the other 31
				// additions then overflow exactly count times
				use_higher_q <= 1'b0;
				acc_q        <= {1'b0, modulation_count};
			end
			else if (sum >= FULL)
			begin
				use_higher_q <= 1'b1;
				acc_q        <= sum - FULL;
			end
			else
			begin
				use_higher_q <= 1'b0;
				acc_q        <= sum;
			end
		end
		else
			frame_start_q <= 1'b0;
	end
endmodule : bcdco_modulator

// file: hdl/bcdco_clock_ctrl.sv
// Basic clock module: aux, main and peripheral clocks with a modulated oscillator
// What this block does
// - The auxiliary clock is chosen between the watch crystal and the internal low-frequency oscillator.
// - A main clock output drives the processor core.
// - A separate peripheral clock output feeds the peripheral modules.
// - The oscillator reports stable 1 us (SETTLE_CYC clock cycles) after being started.
// - A 4-bit range select picks one of sixteen overlapping oscillator ranges.
// - In each 32-cycle frame the modulation count sets how many cycles use the next higher tap; tap 7 cannot go higher and stays put.
// - The remaining cycles of each frame use the selected tap.
// - Calibration bytes live in protected information memory and software loads them here.
// - The frequency control register sits at byte offset 56h for direct calibration writes.
module bcdco_clock_ctrl
#(
	parameter int SETTLE_CYCLES = bcdco_pkg::SETTLE_CYC
)
(
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_write,
	input  wire logic       reg_read,
	output logic      [7:0] reg_rdata,
	input  wire logic       crystal_clk_pin,
	input  wire logic       lf_osc_clk,
	input  wire logic       digital_osc_tick,
	output logic            aux_clock,
	output logic            main_clock,
	output logic            peripheral_clock,
	output logic      [3:0] range_select,
	output logic      [2:0] tap_select,
	output logic            digital_osc_clock,
	output logic            osc_stable
);
	initial
	begin
		if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 255)
			$error("bcdco_clock_ctrl: SETTLE_CYCLES out of range");
	end

	logic [7:0] freq_ctrl_q;
	logic [7:0] range_ctrl_q;
	logic [7:0] clk_ctrl_q;
	logic [7:0] aux_ctrl_q;
	logic [1:0] xtal_sync_q;
	logic [1:0] lf_sync_q;
	logic [1:0] tick_sync_q;
	logic       tick_prev_q;
	logic       osc_tick;
	logic       use_higher;
	logic       frame_start;
	logic [7:0] settle_q;
	logic       aux_level;
	logic       osc_level_q;

	// Register decode returning the stored byte for an offset
	function automatic logic [7:0] read_mux(input logic [7:0] a,
		input logic [7:0] f, input logic [7:0] r,
		input logic [7:0] c, input logic [7:0] x,
		input logic [7:0] s);
		unique case (a)
			bcdco_pkg::OFS_FREQ_CTRL:  read_mux = f;
			bcdco_pkg::OFS_RANGE_CTRL: read_mux = r;
			bcdco_pkg::OFS_CLK_CTRL:   read_mux = c;
			bcdco_pkg::OFS_AUX_CTRL:   read_mux = x;
			bcdco_pkg::OFS_STATUS:     read_mux = s;
			default:                   read_mux = 8'h00;
		endcase
	endfunction : read_mux

	// Clock source selection shared by main and peripheral outputs
	function automatic logic pick_src(input logic [1:0] sel,
		input logic osc, input logic aux);
		unique case (sel)
			bcdco_pkg::BCDCO_SRC_OSC: pick_src = osc;
			bcdco_pkg::BCDCO_SRC_AUX: pick_src = aux;
			default:                  pick_src = 1'b0;
		endcase
	endfunction : pick_src

	// Software-writable registers; calibration bytes land directly at 56h
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			freq_ctrl_q  <= bcdco_pkg::RST_FREQ_CTRL;
			range_ctrl_q <= bcdco_pkg::RST_RANGE_CTRL;
			clk_ctrl_q   <= bcdco_pkg::RST_CLK_CTRL;
			aux_ctrl_q   <= bcdco_pkg::RST_AUX_CTRL;
		end
		else if (reg_write)
		begin
			unique case (reg_addr)
				bcdco_pkg::OFS_FREQ_CTRL:
					freq_ctrl_q <= reg_wdata;
				bcdco_pkg::OFS_RANGE_CTRL:
					range_ctrl_q <= {4'h0, reg_wdata[3:0]};
				bcdco_pkg::OFS_CLK_CTRL:
					clk_ctrl_q <= {4'h0, reg_wdata[3:0]};
				bcdco_pkg::OFS_AUX_CTRL:
					aux_ctrl_q <= {7'h00, reg_wdata[0]};
				default:
					;
			endcase
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			reg_rdata <= 8'h00;
		else if (reg_read)
			reg_rdata <= read_mux(reg_addr, freq_ctrl_q, range_ctrl_q,
				clk_ctrl_q, aux_ctrl_q, {7'h00, osc_stable});
		else
			reg_rdata <= 8'h00;
	end

	// Two-stage synchronisers for the pin and oscillator inputs
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			xtal_sync_q <= 2'b00;
			lf_sync_q   <= 2'b00;
			tick_sync_q <= 2'b00;
			tick_prev_q <= 1'b0;
		end
		else
		begin
			xtal_sync_q <= {xtal_sync_q[0], crystal_clk_pin};
			lf_sync_q   <= {lf_sync_q[0], lf_osc_clk};
			tick_sync_q <= {tick_sync_q[0], digital_osc_tick};
			tick_prev_q <= tick_sync_q[1];
		end
	end

	// One oscillator cycle per rising edge of the synchronised tick
	assign osc_tick = tick_sync_q[1] & ~tick_prev_q;

	bcdco_modulator #(
		.MOD_W (bcdco_pkg::MOD_W)
	) u_mod (
		.clk              (clk),
		.reset_n          (reset_n),
		.osc_tick         (osc_tick),
		.modulation_count (freq_ctrl_q[bcdco_pkg::MOD_LSB +:
			bcdco_pkg::MOD_W]),
		.use_higher_q     (use_higher),
		.frame_start_q    (frame_start)
	);

	// Tap toward the analog oscillator steps up on higher-tap cycles
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			tap_select   <= 3'h0;
			range_select <= 4'h0;
		end
		else
		begin
			range_select <= range_ctrl_q[bcdco_pkg::RSEL_LSB +:
				bcdco_pkg::RSEL_W];
			// Top tap cannot go higher, so it saturates
			if (use_higher && freq_ctrl_q[7:5] != 3'h7)
				tap_select <= freq_ctrl_q[bcdco_pkg::TAP_LSB +:
					bcdco_pkg::TAP_W] + 3'h1;
			else
				tap_select <= freq_ctrl_q[bcdco_pkg::TAP_LSB +:
					bcdco_pkg::TAP_W];
		end
	end

	// Settle counter restarts whenever range or tap is reprogrammed
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			settle_q <= 8'h00;
		else if (reg_write && (reg_addr == bcdco_pkg::OFS_FREQ_CTRL ||
			reg_addr == bcdco_pkg::OFS_RANGE_CTRL))
			settle_q <= 8'h00;
		else if (settle_q < 8'(SETTLE_CYCLES))
			settle_q <= settle_q + 8'h01;
	end

	assign osc_stable = (settle_q >= 8'(SETTLE_CYCLES));

	// Oscillator clock follows the synchronised tick level, held low until stable
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			osc_level_q <= 1'b0;
		else if (osc_stable)
			osc_level_q <= tick_sync_q[1];
		else
			osc_level_q <= 1'b0;
	end

	assign aux_level = aux_ctrl_q[bcdco_pkg::AUX_SEL_BIT] ?
		lf_sync_q[1] : xtal_sync_q[1];

	// Output clocks registered to avoid glitches on source change
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			aux_clock         <= 1'b0;
			main_clock        <= 1'b0;
			peripheral_clock  <= 1'b0;
			digital_osc_clock <= 1'b0;
		end
		else
		begin
			aux_clock         <= aux_level;
			main_clock        <= pick_src(clk_ctrl_q[1:0],
				osc_level_q, aux_level);
			peripheral_clock  <= pick_src(clk_ctrl_q[3:2],
				osc_level_q, aux_level);
			digital_osc_clock <= osc_level_q;
		end
	end
endmodule : bcdco_clock_ctrl

// file: verif/bcdco_checker.sv
// Port checker of the clock block
module bcdco_checker
#(
	parameter int SETTLE_CYCLES = 50
)
(
	input wire logic       clk,
	input wire logic       reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_write,
	input wire logic       reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic [3:0] range_select,
	input wire logic [2:0] tap_select,
	input wire logic       main_clock,
	input wire logic       peripheral_clock,
	input wire logic       digital_osc_clock,
	input wire logic       osc_stable
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] f_q, c_q, run_q, quiet_q;
	logic       restart;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Oscillator setting writes restart the settle count
	assign restart = reg_write && (reg_addr == 8'h56 || reg_addr == 8'h57);
	// Shadow registers; quiet_q saturates so long runs never wrap
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			f_q <= 8'h60;
			c_q <= 8'h00;
			quiet_q <= 8'h00;
			run_q <= 8'h00;
		end
		else
		begin
			if (reg_write && reg_addr == 8'h56)
				f_q <= reg_wdata;
			if (reg_write && reg_addr == 8'h58)
				c_q <= reg_wdata;
			quiet_q <= reg_write ? 8'h00 : quiet_q + {7'h00, quiet_q != 8'hff};
			run_q <= restart ? 8'h00 : run_q + {7'h00, run_q != 8'hff};
		end
	end
	rdata_idle_a: assert property (reg_rdata != 8'h00 |-> $past(reg_read))
		else $error("read data outside read answer cycle");
	range_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
		(reg_write && reg_addr == 8'h57 ##1 1'b1) |-> ##1 range_select == $past(reg_wdata[3:0], 2))
		else $error("range select not taken from write");
	restart_low_a: assert property (restart |=> !osc_stable)
		else $error("stable kept after restart");
	settle_min_a: assert property (osc_stable |-> run_q >= SETTLE_CYCLES - 1)
		else $error("stable too early");
	settle_max_a: assert property (run_q >= SETTLE_CYCLES + 2 |-> osc_stable)
		else $error("stable too late");
	// Gate acts on the internal level, which reaches the pin one edge later
	osc_gated_a: assert property (!osc_stable |-> ##2 !digital_osc_clock)
		else $error("oscillator clock runs while unstable");
	main_off_a: assert property (c_q[1] && quiet_q > 8'h05 |-> !main_clock)
		else $error("main clock not off");
	periph_off_a: assert property (c_q[3] && quiet_q > 8'h05 |-> !peripheral_clock)
		else $error("peripheral clock not off");
	// A stale higher cycle may last one oscillator tick plus the sync delay
	tap_base_a: assert property (f_q[4:0] == 5'h00 && quiet_q > 8'h10 |-> tap_select == f_q[7:5])
		else $error("tap moved with zero modulation");
	// Main scenarios reached
	restart_c: cover property (restart);
	stable_c: cover property ($rose(osc_stable));
	higher_c: cover property (tap_select != f_q[7:5]);
endmodule : bcdco_checker

// file: verif/basic_clock_dco_modulation_bench.sv
// Self-checking bench of the clock block
module basic_clock_dco_modulation_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SETTLE = 20;
	logic       clk, reset_n, reg_write, reg_read, tick_run;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic       crystal_clk_pin, lf_osc_clk, digital_osc_tick;
	logic       aux_clock, main_clock, peripheral_clock;
	logic       digital_osc_clock, osc_stable;
	logic [3:0] range_select;
	logic [2:0] tap_select;
	int         err_count, total_checks, tick_cnt;
	bcdco_clock_ctrl #(.SETTLE_CYCLES(SETTLE)) dut_u (.clk(clk), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .crystal_clk_pin(crystal_clk_pin),
		.lf_osc_clk(lf_osc_clk), .digital_osc_tick(digital_osc_tick),
		.aux_clock(aux_clock), .main_clock(main_clock),
		.peripheral_clock(peripheral_clock), .range_select(range_select),
		.tap_select(tap_select), .digital_osc_clock(digital_osc_clock),
		.osc_stable(osc_stable));
	always #10 clk = ~clk;
	// Oscillator ticks with an eight-cycle period while enabled
	always @(posedge clk)
	begin
		tick_cnt <= reset_n ? tick_cnt + 1 : 0;
		if (!reset_n)
			digital_osc_tick <= 1'b0;
		else if (!tick_run)
			digital_osc_tick <= 1'b1;
		else if (tick_cnt % 4 == 3)
			digital_osc_tick <= ~digital_osc_tick;
	end
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1;
		chk("reg", e, reg_rdata);
	endtask : rc
	task automatic settle_case;
		int n;
		n = 0;
		// Step past the edge so the restarted count is visible
		#1;
		while (osc_stable !== 1'b1 && n < 200)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		total_checks++;
		if (n < SETTLE - 1 || n > SETTLE + 2)
		begin
			err_count++;
			$display("[FAIL] settle expected %0d seen %0d", SETTLE, n);
		end
	endtask : settle_case
	// Reset values, masked bits, unmapped place
	task automatic regs_case;
		rc(8'h5a, 8'h01);
		rc(8'h56, 8'h60);
		rc(8'h57, 8'h07);
		rc(8'h58, 8'h00);
		rc(8'h53, 8'h00);
		wr(8'h10, 8'h55);
		rc(8'h10, 8'h00);
		wr(8'h57, 8'hff);
		rc(8'h57, 8'h0f);
		chk("range", 8'h0f, {4'h0, range_select});
		wr(8'h56, 8'ha3);
		rc(8'h56, 8'ha3);
		rc(8'h5a, 8'h00);
	endtask : regs_case
	// Higher-tap count per frame, and spread for small counts
	task automatic mod_case(input logic [4:0] m);
		int hi;
		logic prev;
		hi = 0;
		prev = 1'b0;
		wr(8'h56, {3'h2, m});
		settle_case();
		// Let the frame cut by the rewrite finish before counting
		repeat (256) @(posedge clk);
		for (int i = 0; i < 32; i++)
		begin
			repeat (8) @(posedge clk);
			#1;
			if (tap_select !== 3'h2)
				chk("tap", 8'h03, {5'h0, tap_select});
			if (m <= 5'h10 && prev && tap_select === 3'h3)
				chk("spread", 8'h02, 8'h03);
			prev = (tap_select === 3'h3);
			hi += prev;
		end
		chk("higher", {3'h0, m}, hi[7:0]);
	endtask : mod_case
	// Software-style walk of a tagged calibration image, then direct load
	task automatic cal_case;
		logic [7:0] img [16'h10c0:16'h10ff];
		int         a;
		for (int i = 16'h10c0; i <= 16'h10ff; i++)
			img[i] = 8'hff;
		img[16'h10c0] = 8'hfe; // Empty area reaching up to the record
		img[16'h10c1] = 8'h34;
		img[16'h10f6] = 8'h01;
		img[16'h10f7] = 8'h08;
		img[16'h10fe] = 8'h5c;
		img[16'h10ff] = 8'h8b;
		a = 16'h10c0;
		while (a < 16'h10f8 && img[a] !== 8'h01)
			a = a + 2 + int'(img[a + 1]);
		chk("cal_tag", 8'hf6, a[7:0]);
		chk("cal_page", 8'h10, a[15:8]);
		wr(8'h56, img[a + 8]);
		wr(8'h57, img[a + 9]);
		settle_case();
		rc(8'h56, img[a + 8]);
		rc(8'h57, {4'h0, img[a + 9][3:0]});
		chk("range", {4'h0, img[a + 9][3:0]}, {4'h0, range_select});
	endtask : cal_case
	// Aux and source selection with static levels
	task automatic src_case;
		// Oscillator input parks high, so the oscillator source reads 1
		tick_run = 1'b0;
		crystal_clk_pin <= 1'b1;
		wr(8'h53, 8'h00);
		repeat (8) @(posedge clk);
		chk("aux", 8'h01, {7'h0, aux_clock});
		wr(8'h53, 8'h01);
		repeat (8) @(posedge clk);
		chk("aux", 8'h00, {7'h0, aux_clock});
		crystal_clk_pin <= 1'b0;
		lf_osc_clk <= 1'b1;
		wr(8'h53, 8'h00);
		for (int s = 0; s < 4; s++)
		begin
			wr(8'h58, {4'h0, s[1:0], s[1:0]});
			repeat (8) @(posedge clk);
			chk("main", {7'h0, s == 0}, {7'h0, main_clock});
			chk("peri", {7'h0, s == 0}, {7'h0, peripheral_clock});
		end
		wr(8'h58, 8'h04);
		repeat (8) @(posedge clk);
		chk("main", 8'h01, {7'h0, main_clock});
		chk("peri", 8'h00, {7'h0, peripheral_clock});
		// Aux high now, so aux and off selections differ
		crystal_clk_pin <= 1'b1;
		wr(8'h58, 8'h06);
		repeat (8) @(posedge clk);
		chk("main", 8'h00, {7'h0, main_clock});
		chk("peri", 8'h01, {7'h0, peripheral_clock});
	endtask : src_case
	task automatic wrap_up;
		if (err_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	initial
	begin
		#200000;
		err_count++;
		wrap_up();
	end
	initial
	begin
		clk = 1'b0;
		reset_n = 1'b0;
		{reg_write, reg_read, reg_addr, reg_wdata} = '0;
		{crystal_clk_pin, lf_osc_clk} = '0;
		tick_run = 1'b1;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		settle_case();
		regs_case();
		mod_case(5'h00);
		mod_case(5'h01);
		mod_case(5'h10);
		mod_case(5'h1f);
		cal_case();
		src_case();
		wrap_up();
	end
endmodule : basic_clock_dco_modulation_bench
bind bcdco_clock_ctrl bcdco_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk_u (
	.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.range_select(range_select), .tap_select(tap_select),
	.main_clock(main_clock), .peripheral_clock(peripheral_clock),
	.digital_osc_clock(digital_osc_clock), .osc_stable(osc_stable));
